// ---- asp_pkg.sv ----
package asp_pkg;

  typedef enum logic [1:0] {
    ASP_MODE_SHIFT,
    ASP_MODE_UART8,
    ASP_MODE_UART9_FIXED,
    ASP_MODE_UART9_VAR
  } asp_mode_t;

  localparam int CLK_SYS_MHZ = 250;
  localparam int MODE0_CLK_DIV = 2;
  localparam int MODE2_CLK_DIV = 64;
  localparam int OVERSAMPLE = 16;
  localparam int MODE2_PRESCALE = MODE2_CLK_DIV / OVERSAMPLE;
  localparam logic [1:0] MODE2_PRESCALE_LAST = 2'(MODE2_PRESCALE - 1);
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] SHIFT_LAST_BIT = 4'h7;
  localparam logic [3:0] BITS_UART8 = 4'h8;
  localparam logic [3:0] BITS_UART9 = 4'h9;
  localparam int BREAK_BITS = 11;
  localparam logic [7:0] BREAK_TICKS = 8'(BREAK_BITS * OVERSAMPLE);
  localparam logic [7:0] SYNCH_BYTE = 8'h55;
  localparam int BRG_INT_W = 11;
  localparam int BRG_FRAC_W = 5;
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 8;
  localparam logic [7:0] RX_BUF_RESET = 8'h00;

endpackage

// ---- asp_fifo_if.sv ----
`timescale 1ns/1ps
interface asp_fifo_if #(parameter int WIDTH = 9);
  logic pushValid;
  logic pushReady;
  logic [WIDTH-1:0] pushData;
  logic popValid;
  logic popReady;
  logic [WIDTH-1:0] popData;

  modport store (
    input pushValid,
    output pushReady,
    input pushData,
    output popValid,
    input popReady,
    output popData
  );

  modport user (
    output pushValid,
    input pushReady,
    output pushData,
    input popValid,
    output popReady,
    input popData
  );
endinterface

// ---- asp_fifo.sv ----
`timescale 1ns/1ps
module asp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  asp_fifo_if.store fifoPort
);
  // depth must be a power of two, pointers wrap naturally
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_ff;
  logic [AW-1:0] rdPtr_ff;
  logic [AW:0] count_ff;
  logic doPush;
  logic doPop;

  assign fifoPort.pushReady = (count_ff != FULL_COUNT);
  assign fifoPort.popValid = (count_ff != '0);
  assign fifoPort.popData = mem[rdPtr_ff];
  assign doPush = clkEn && fifoPort.pushValid && fifoPort.pushReady;
  assign doPop = clkEn && fifoPort.popValid && fifoPort.popReady;

  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      mem[wrPtr_ff] <= fifoPort.pushData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (doPush) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (doPop) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
      if (doPush && !doPop) begin
        count_ff <= count_ff + 1'b1;
      end else if (doPop && !doPush) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

// ---- asp_serial_port.sv ----
`timescale 1ns/1ps
module asp_serial_port (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic modeSelectHigh,
  input wire logic modeSelectLow,
  input wire logic rxEnable,
  input wire logic [asp_pkg::BRG_INT_W-1:0] brgReload,
  input wire logic [asp_pkg::BRG_FRAC_W-1:0] brgFraction,
  input wire logic bufWrite,
  input wire logic [7:0] bufWrData,
  input wire logic txNinthBit,
  output logic bufWrReady,
  input wire logic bufRead,
  output logic [7:0] bufRdData,
  output logic rxNinthBit,
  output logic rxFull,
  output logic txIrq,
  output logic rxIrq,
  output logic overrun,
  output logic framingError,
  output logic breakDetected,
  output logic synchDetected,
  input wire logic rxdIn,
  output logic rxdOut,
  output logic rxdOe,
  output logic txdOut
);

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_SHIFT} asp_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_SHIFT} asp_rx_state_t;

  function automatic logic [3:0] frameBits(input asp_pkg::asp_mode_t m);
    frameBits = (m == asp_pkg::ASP_MODE_UART8) ? asp_pkg::BITS_UART8 : asp_pkg::BITS_UART9;
  endfunction

  asp_pkg::asp_mode_t mode;
  logic rxdMeta_ff;
  logic rxdSync_ff;
  logic rxdPrev_ff;
  logic [asp_pkg::BRG_INT_W-1:0] brgCnt_ff;
  logic [asp_pkg::BRG_FRAC_W-1:0] fracAcc_ff;
  logic [asp_pkg::BRG_FRAC_W:0] fracSum;
  logic [1:0] pre_ff;
  logic brgTick;
  logic preTick;
  logic sampleTick;

  asp_tx_state_t txState_ff;
  logic [8:0] txShift_ff;
  logic [3:0] txTick_ff;
  logic [3:0] txBit_ff;
  logic txLine_ff;
  logic txPhase_ff;
  logic txIrq_ff;
  logic txPop;

  asp_rx_state_t rxState_ff;
  logic [8:0] rxShift_ff;
  logic [3:0] rxTick_ff;
  logic [3:0] rxBit_ff;
  logic rxPhase_ff;
  logic rxDone_ff;
  logic rxStopOk_ff;
  logic rxStart0;

  logic [7:0] rxBuf_ff;
  logic rxNinth_ff;
  logic rxFull_ff;
  logic rxIrq_ff;
  logic overrun_ff;
  logic framingError_ff;
  logic [7:0] lowCnt_ff;
  logic breakSeen_ff;
  logic breakDetected_ff;
  logic synchDetected_ff;

  asp_fifo_if #(.WIDTH(asp_pkg::FIFO_WIDTH)) txFifo ();

  asp_fifo #(
    .WIDTH(asp_pkg::FIFO_WIDTH),
    .DEPTH(asp_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .clkEn(clkEn),
    .fifoPort(txFifo.store)
  );

  assign mode = asp_pkg::asp_mode_t'({modeSelectHigh, modeSelectLow});

  // buffer writes queue into the transmit fifo
  assign txFifo.pushValid = bufWrite;
  assign txFifo.pushData = {txNinthBit, bufWrData};
  assign bufWrReady = txFifo.pushReady;

  // mode 0 is half duplex on one data pin; transmit wins a tie
  assign rxStart0 = (mode == asp_pkg::ASP_MODE_SHIFT) && (rxState_ff == RX_IDLE) && rxEnable && !rxFull_ff
                    && (txState_ff == TX_IDLE) && !txFifo.popValid;
  assign txPop = txFifo.popValid && (txState_ff == TX_IDLE)
                 && !((mode == asp_pkg::ASP_MODE_SHIFT) && (rxState_ff == RX_SHIFT));
  assign txFifo.popReady = txPop;

  // the pin is asynchronous to the clock
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxdMeta_ff <= 1'b1;
      rxdSync_ff <= 1'b1;
      // idle high after reset, so release is never a false start
      rxdPrev_ff <= 1'b1;
    end else if (clkEn) begin
      rxdMeta_ff <= rxdIn;
      rxdSync_ff <= rxdMeta_ff;
      rxdPrev_ff <= rxdSync_ff;
    end
  end

  // baud generator: integer reload plus fractional carry stretches a period by one
  assign fracSum = {1'b0, fracAcc_ff} + {1'b0, brgFraction};
  assign brgTick = (brgCnt_ff == '0);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      brgCnt_ff <= '0;
      fracAcc_ff <= '0;
    end else if (clkEn) begin
      if (brgTick) begin
        brgCnt_ff <= brgReload + asp_pkg::BRG_INT_W'(fracSum[asp_pkg::BRG_FRAC_W]);
        fracAcc_ff <= fracSum[asp_pkg::BRG_FRAC_W-1:0];
      end else begin
        brgCnt_ff <= brgCnt_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pre_ff <= '0;
    end else if (clkEn) begin
      pre_ff <= pre_ff + 1'b1;
    end
  end

  assign preTick = (pre_ff == asp_pkg::MODE2_PRESCALE_LAST);
  // sixteen ticks per bit: fixed prescale gives clock/64, otherwise underflows
  assign sampleTick = (mode == asp_pkg::ASP_MODE_UART9_FIXED) ? preTick : brgTick;

  // transmitter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txState_ff <= TX_IDLE;
      txShift_ff <= '0;
      txTick_ff <= '0;
      txBit_ff <= '0;
      txLine_ff <= 1'b1;
      txPhase_ff <= 1'b0;
      txIrq_ff <= 1'b0;
    end else if (clkEn) begin
      txIrq_ff <= 1'b0;
      unique case (txState_ff)
        TX_IDLE: begin
          txLine_ff <= 1'b1;
          if (txPop) begin
            txShift_ff <= txFifo.popData;
            txTick_ff <= '0;
            txBit_ff <= '0;
            txPhase_ff <= 1'b0;
            if (mode == asp_pkg::ASP_MODE_SHIFT) begin
              txState_ff <= TX_SHIFT;
            end else begin
              txState_ff <= TX_START;
              txLine_ff <= 1'b0;
            end
          end
        end
        TX_START: begin
          if (sampleTick) begin
            txTick_ff <= txTick_ff + 1'b1;
            if (txTick_ff == asp_pkg::TICK_LAST) begin
              txState_ff <= TX_DATA;
              txLine_ff <= txShift_ff[0];
            end
          end
        end
        TX_DATA: begin
          if (sampleTick) begin
            txTick_ff <= txTick_ff + 1'b1;
            if (txTick_ff == asp_pkg::TICK_LAST) begin
              if (txBit_ff == frameBits(mode) - 4'h1) begin
                txState_ff <= TX_STOP;
                txLine_ff <= 1'b1;
              end else begin
                txBit_ff <= txBit_ff + 1'b1;
                txShift_ff <= {1'b0, txShift_ff[8:1]};
                txLine_ff <= txShift_ff[1];
              end
            end
          end
        end
        TX_STOP: begin
          if (sampleTick) begin
            txTick_ff <= txTick_ff + 1'b1;
            if (txTick_ff == asp_pkg::TICK_LAST) begin
              txState_ff <= TX_IDLE;
              txIrq_ff <= 1'b1;
            end
          end
        end
        TX_SHIFT: begin
          // one bit per two clocks, shift clock low then high
          txPhase_ff <= !txPhase_ff;
          if (txPhase_ff) begin
            if (txBit_ff == asp_pkg::SHIFT_LAST_BIT) begin
              txState_ff <= TX_IDLE;
              txIrq_ff <= 1'b1;
            end else begin
              txBit_ff <= txBit_ff + 1'b1;
              txShift_ff <= {1'b0, txShift_ff[8:1]};
            end
          end
        end
      endcase
    end
  end

  // receiver
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxState_ff <= RX_IDLE;
      rxShift_ff <= '0;
      rxTick_ff <= '0;
      rxBit_ff <= '0;
      rxPhase_ff <= 1'b0;
      rxDone_ff <= 1'b0;
      rxStopOk_ff <= 1'b0;
    end else if (clkEn) begin
      rxDone_ff <= 1'b0;
      unique case (rxState_ff)
        RX_IDLE: begin
          rxTick_ff <= '0;
          rxBit_ff <= '0;
          rxPhase_ff <= 1'b0;
          // a UART frame may start even while the buffer is full; mode 0 waits until it is read
          if (mode != asp_pkg::ASP_MODE_SHIFT) begin
            // falling edge only: a low stop or a break must not restart a frame
            if (rxEnable && rxdPrev_ff && !rxdSync_ff) begin
              rxState_ff <= RX_START;
            end
          end else if (rxStart0) begin
            rxState_ff <= RX_SHIFT;
          end
        end
        RX_START: begin
          if (sampleTick) begin
            rxTick_ff <= rxTick_ff + 1'b1;
            if (rxTick_ff == asp_pkg::TICK_MID) begin
              // glitch shorter than half a bit is not a start
              if (rxdSync_ff) begin
                rxState_ff <= RX_IDLE;
              end else begin
                rxState_ff <= RX_DATA;
                rxTick_ff <= '0;
              end
            end
          end
        end
        RX_DATA: begin
          if (sampleTick) begin
            rxTick_ff <= rxTick_ff + 1'b1;
            if (rxTick_ff == asp_pkg::TICK_LAST) begin
              rxShift_ff[rxBit_ff] <= rxdSync_ff;
              if (rxBit_ff == frameBits(mode) - 4'h1) begin
                rxState_ff <= RX_STOP;
              end else begin
                rxBit_ff <= rxBit_ff + 1'b1;
              end
            end
          end
        end
        RX_STOP: begin
          if (sampleTick) begin
            rxTick_ff <= rxTick_ff + 1'b1;
            if (rxTick_ff == asp_pkg::TICK_LAST) begin
              // in 8-bit mode the stop bit takes the ninth slot
              if (mode == asp_pkg::ASP_MODE_UART8) begin
                rxShift_ff[8] <= rxdSync_ff;
              end
              rxStopOk_ff <= rxdSync_ff;
              rxDone_ff <= 1'b1;
              rxState_ff <= RX_IDLE;
            end
          end
        end
        RX_SHIFT: begin
          rxPhase_ff <= !rxPhase_ff;
          if (rxPhase_ff) begin
            rxShift_ff[rxBit_ff] <= rxdSync_ff;
            if (rxBit_ff == asp_pkg::SHIFT_LAST_BIT) begin
              rxShift_ff[8] <= 1'b0;
              rxStopOk_ff <= 1'b1;
              rxDone_ff <= 1'b1;
              rxState_ff <= RX_IDLE;
            end else begin
              rxBit_ff <= rxBit_ff + 1'b1;
            end
          end
        end
      endcase
    end
  end

  // receive buffer: a read in the same cycle as a completion frees the slot first
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxBuf_ff <= asp_pkg::RX_BUF_RESET;
      rxNinth_ff <= 1'b0;
      rxFull_ff <= 1'b0;
      rxIrq_ff <= 1'b0;
      overrun_ff <= 1'b0;
      framingError_ff <= 1'b0;
    end else if (clkEn) begin
      rxIrq_ff <= 1'b0;
      overrun_ff <= 1'b0;
      framingError_ff <= 1'b0;
      if (rxDone_ff && !rxStopOk_ff) begin
        framingError_ff <= 1'b1;
        if (bufRead) begin
          rxFull_ff <= 1'b0;
        end
      end else if (rxDone_ff && rxFull_ff && !bufRead) begin
        overrun_ff <= 1'b1;
      end else if (rxDone_ff) begin
        rxBuf_ff <= rxShift_ff[7:0];
        rxNinth_ff <= rxShift_ff[8];
        rxFull_ff <= 1'b1;
        rxIrq_ff <= 1'b1;
      end else if (bufRead) begin
        rxFull_ff <= 1'b0;
      end
    end
  end

  // break: line low for longer than any legal frame
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lowCnt_ff <= '0;
      breakDetected_ff <= 1'b0;
    end else if (clkEn) begin
      breakDetected_ff <= 1'b0;
      if (mode == asp_pkg::ASP_MODE_SHIFT || rxdSync_ff) begin
        lowCnt_ff <= '0;
      end else if (sampleTick && lowCnt_ff != asp_pkg::BREAK_TICKS) begin
        lowCnt_ff <= lowCnt_ff + 1'b1;
        if (lowCnt_ff == asp_pkg::BREAK_TICKS - 8'h01) begin
          breakDetected_ff <= 1'b1;
        end
      end
    end
  end

  // synch: the first frame after a break is compared with 0x55 if its stop bit is good
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      breakSeen_ff <= 1'b0;
      synchDetected_ff <= 1'b0;
    end else if (clkEn) begin
      synchDetected_ff <= 1'b0;
      if (breakDetected_ff) begin
        breakSeen_ff <= 1'b1;
      end else if (rxDone_ff) begin
        breakSeen_ff <= 1'b0;
        if (breakSeen_ff && rxStopOk_ff && rxShift_ff[7:0] == asp_pkg::SYNCH_BYTE) begin
          synchDetected_ff <= 1'b1;
        end
      end
    end
  end

  assign bufRdData = rxBuf_ff;
  assign rxNinthBit = rxNinth_ff;
  assign rxFull = rxFull_ff;
  assign txIrq = txIrq_ff;
  assign rxIrq = rxIrq_ff;
  assign overrun = overrun_ff;
  assign framingError = framingError_ff;
  assign breakDetected = breakDetected_ff;
  assign synchDetected = synchDetected_ff;
  assign rxdOut = txShift_ff[0];
  assign rxdOe = (txState_ff == TX_SHIFT);
  // shift clock idles high between mode 0 transfers
  assign txdOut = (txState_ff == TX_SHIFT) ? txPhase_ff :
                  (rxState_ff == RX_SHIFT) ? rxPhase_ff : txLine_ff;

endmodule

// ---- asp_serial_chk.sv ----
`timescale 1ns/1ps
module asp_serial_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic modeSelectHigh,
  input wire logic modeSelectLow,
  input wire logic bufWrReady,
  input wire logic [7:0] bufRdData,
  input wire logic rxFull,
  input wire logic txIrq,
  input wire logic rxIrq,
  input wire logic overrun,
  input wire logic framingError,
  input wire logic breakDetected,
  input wire logic rxdOe,
  input wire logic txdOut
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [15:0] lowCnt_ff;
  wire inMode0 = !modeSelectHigh && !modeSelectLow;
  wire inMode2 = modeSelectHigh && !modeSelectLow;
  // length of the current low run on txdOut
  always_ff @(posedge clk_sys) begin
    if (rst || txdOut) lowCnt_ff <= 16'h0000;
    else lowCnt_ff <= lowCnt_ff + 16'h0001;
  end
  AST_IDLE: assert property ($fell(rst) |-> txdOut && !rxdOe && bufWrReady && !rxFull)
    else $error("not idle after reset");
  AST_OE_M0: assert property (rxdOe |-> inMode0)
    else $error("pin driven outside mode 0");
  AST_M0_LOW: assert property (inMode0 && rxdOe && $fell(txdOut) |=> txdOut)
    else $error("shift clock low too long");
  AST_M0_HIGH: assert property (inMode0 && rxdOe && $rose(txdOut) |=> !txdOut || !rxdOe)
    else $error("shift clock high too long");
  // first bit may lose up to one tick of prescale alignment
  AST_M2_BIT: assert property (inMode2 && $rose(txdOut) |->
    lowCnt_ff > 16'h003c && ((lowCnt_ff + 16'h0003) & 16'h003f) <= 16'h0003)
    else $error("mode 2 bit time wrong");
  AST_TX_PULSE: assert property (txIrq |=> !txIrq)
    else $error("tx pulse too long");
  AST_RX_FULL: assert property (rxIrq |-> rxFull)
    else $error("rx pulse without full buffer");
  AST_BUF_HOLD: assert property ($changed(bufRdData) |-> rxIrq)
    else $error("receive register changed without frame");
  AST_OVR: assert property (overrun |-> rxFull && !rxIrq)
    else $error("overrun replaced old byte");
  AST_FE: assert property (framingError |-> !rxIrq && !overrun)
    else $error("bad stop frame stored");
  AST_BRK: assert property (breakDetected |-> !inMode0)
    else $error("break flagged in mode 0");
endmodule
bind asp_serial_port asp_serial_chk chk (.clk_sys, .rst, .modeSelectHigh, .modeSelectLow, .bufWrReady,
  .bufRdData, .rxFull, .txIrq, .rxIrq, .overrun, .framingError, .breakDetected, .rxdOe, .txdOut);

// ---- asp_remote_node.sv ----
`timescale 1ns/1ps
module asp_remote_node (
  input wire logic clk_sys,
  input wire logic txdOut,
  output logic rxdLine
);
  int bitClk = 64;
  int nBits = 9;
  bit listen = 1'b1;
  logic [9:0] got[$];
  initial rxdLine = 1'b1;
  task automatic waitClk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic sendFrame(input logic [8:0] d, input logic stopLvl);
    rxdLine <= 1'b0;
    waitClk(bitClk);
    for (int i = 0; i < nBits; i++) begin
      rxdLine <= d[i];
      waitClk(bitClk);
    end
    rxdLine <= stopLvl;
    waitClk(bitClk);
    rxdLine <= 1'b1;
    // short idle only, a real node may be this quick
    waitClk(bitClk / 2);
  endtask
  task automatic holdLow(input int bits);
    rxdLine <= 1'b0;
    waitClk(bits * bitClk);
    rxdLine <= 1'b1;
  endtask
  // listener runs apart from sendFrame
  always begin : listener
    logic [8:0] v;
    @(posedge clk_sys);
    if (listen && txdOut === 1'b0) begin
      v = 9'h000;
      waitClk(bitClk / 2);
      for (int i = 0; i < nBits; i++) begin
        waitClk(bitClk);
        v[i] = txdOut;
      end
      waitClk(bitClk);
      got.push_back({txdOut, v});
    end
  end
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0, rst = 1'b1, rxEnable = 1'b1, bufWrite = 1'b0, bufRead = 1'b0;
  logic modeSelectHigh = 1'b1, modeSelectLow = 1'b0, txNinthBit = 1'b0;
  logic [10:0] brgReload = 11'h000;
  logic [4:0] brgFraction = 5'h00;
  logic [7:0] bufWrData = 8'h00, bufRdData, m0Sh;
  logic bufWrReady, rxNinthBit, rxFull, txIrq, rxIrq, overrun, framingError, breakDetected;
  logic synchDetected, rxdOut, rxdOe, txdOut, rxLine;
  int fails = 0, compares = 0, cyc = 0, nTx = 0, nRx = 0, nOvr = 0, nFe = 0, nBrk = 0, nSyn = 0;
  int mm[3] = '{1, 3, 3}, rl[3] = '{1, 2, 1}, fr[3] = '{0, 0, 16}, bc[3] = '{32, 48, 40};
  integer seed = 32'haa12a545;
  logic [9:0] txExp[$];
  // shared pin: device wins while it drives
  wire rxdPin = rxdOe === 1'b1 ? rxdOut : rxLine;
  always #2 clk_sys = ~clk_sys;
  asp_serial_port uut (.clk_sys, .rst, .clkEn(1'b1), .modeSelectHigh, .modeSelectLow, .rxEnable,
    .brgReload, .brgFraction, .bufWrite, .bufWrData, .txNinthBit, .bufWrReady, .bufRead, .bufRdData,
    .rxNinthBit, .rxFull, .txIrq, .rxIrq, .overrun, .framingError, .breakDetected, .synchDetected,
    .rxdIn(rxdPin), .rxdOut, .rxdOe, .txdOut);
  asp_remote_node rn (.clk_sys, .txdOut, .rxdLine(rxLine));
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (!rst) begin
      nTx += (txIrq === 1'b1);
      nRx += (rxIrq === 1'b1);
      nOvr += (overrun === 1'b1);
      nFe += (framingError === 1'b1);
      nBrk += (breakDetected === 1'b1);
      nSyn += (synchDetected === 1'b1);
      if (rxdOe === 1'b1 && txdOut === 1'b0) m0Sh = {rxdOut, m0Sh[7:1]};
    end
    if (cyc == 40000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic check(input string nm, input logic [9:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cfg(input logic [1:0] m, input int r, f, b, n);
    {modeSelectHigh, modeSelectLow} <= m;
    brgReload <= 11'(r);
    brgFraction <= 5'(f);
    rn.bitClk = b;
    rn.nBits = n;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [8:0] w);
    for (int t = 0; t < 9000 && bufWrReady !== 1'b1; t++) @(posedge clk_sys);
    bufWrite <= 1'b1;
    {txNinthBit, bufWrData} <= w;
    @(posedge clk_sys);
    bufWrite <= 1'b0;
    if (rn.listen) txExp.push_back({1'b1, rn.nBits == 8 ? 1'b0 : w[8], w[7:0]});
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [8:0] e);
    for (int t = 0; t < 3000 && rxFull !== 1'b1; t++) @(posedge clk_sys);
    check("rxData", {1'b0, rxNinthBit, bufRdData}, {1'b0, e});
    bufRead <= 1'b1;
    @(posedge clk_sys);
    bufRead <= 1'b0;
    @(posedge clk_sys);
    check("rxFull", rxFull, 10'h000);
  endtask
  task automatic drainTx();
    for (int t = 0; t < 30000 && rn.got.size() < txExp.size(); t++) @(posedge clk_sys);
    while (txExp.size() > 0)
      check("txFrame", rn.got.size() > 0 ? rn.got.pop_front() : 10'h000, txExp.pop_front());
  endtask
  initial begin
    logic [8:0] d;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check("idle", {txdOut, rxdOe, bufRdData}, 10'h200);
    cfg(2'b10, 0, 0, 64, 9);
    fork
      begin
        for (int i = 0; i < 9; i++) wr(9'($random(seed)));
        check("wrReady", bufWrReady, 10'h000);
        // refused write, must not reach the line
        bufWrite <= 1'b1;
        @(posedge clk_sys);
        bufWrite <= 1'b0;
      end
      repeat (2) begin
        d = 9'($random(seed));
        rn.sendFrame(d, 1'b1);
        rd(d);
      end
    join
    drainTx();
    for (int i = 0; i < 3; i++) begin
      cfg(2'(mm[i]), rl[i], fr[i], bc[i], mm[i] == 1 ? 8 : 9);
      d = 9'($random(seed));
      fork
        wr(9'($random(seed)));
        rn.sendFrame(d, 1'b1);
      join
      rd(mm[i] == 1 ? {1'b1, d[7:0]} : d);
      drainTx();
    end
    cfg(2'b01, 1, 0, 32, 8);
    rn.sendFrame(9'($random(seed)), 1'b0);
    rn.sendFrame(9'h0aa, 1'b1);
    rn.sendFrame(9'($random(seed)), 1'b1);
    rd(9'h1aa);
    rn.holdLow(13);
    rn.waitClk(64);
    rn.sendFrame(9'h055, 1'b1);
    rd(9'h155);
    check("events", {2'b00, nBrk[1:0], nSyn[1:0], nOvr[1:0], nFe[1:0]}, 10'h056);
    check("txIrqs", 10'(nTx), 10'h00c);
    check("rxIrqs", 10'(nRx), 10'h007);
    rn.listen = 1'b0;
    rxEnable <= 1'b0;
    cfg(2'b00, 1, 0, 32, 8);
    d = 9'($random(seed));
    wr(d);
    for (int t = 0; t < 500 && (nTx < 13 || rxdOe === 1'b1); t++) @(posedge clk_sys);
    check("shiftOut", {2'b00, m0Sh}, {2'b00, d[7:0]});
    check("txLeft", 10'(rn.got.size()), 10'h000);
    // mode 0 receive: line drops between the second and third sample points; the two-flop synchronizer delays it past the third
    rxEnable <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rn.rxdLine <= 1'b0;
    rd(9'h007);
    tally_and_finish();
  end
endmodule
